// [itc_interval_timer.sv]
// Interval timer counter with time registers and APB register access
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
module itc_interval_timer
  import itc_pkg::*;
(
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  // Crystal and power state pins
  input  wire logic         i_xtal,
  input  wire logic         i_power_down,
  // APB slave
  input  wire itc_apb_req_s i_apb,
  output      logic         o_pready,
  output      logic         o_pslverr,
  output      logic [31:0]  o_prdata,
  // Interrupt and wake
  output      logic         o_irq,
  output      logic         o_wake,
  output      logic [15:0]  o_irq_vector
);

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  typedef struct packed {
    // Input synchronisers
    logic        xtal_s1;
    logic        xtal_s2;
    logic        xtal_s3;
    logic        pd_s1;
    logic        pd_s2;
    // Crystal prescaler, running time and preset copy
    logic [7:0]  pre;
    itc_time_s   live;
    itc_time_s   shadow;
    // Software registers and interval count
    logic [7:0]  control;
    logic [7:0]  compare;
    logic [7:0]  interval;
    logic        int_en;
    // Bus answer
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    // Interrupt outputs
    logic        irq;
    logic        wake;
    logic [15:0] vector;
  } itc_state_s;

  itc_state_s state_ff;
  itc_state_s nxt_state;

  // -----------------------------------------------------------------------
  // Address decode
  // -----------------------------------------------------------------------
  // Listed one by one so a gap in the map never decodes as a register
  function automatic logic itc_mapped(input logic [11:0] addr);
    logic [7:0] idx;
    idx        = addr[9:2];
    itc_mapped = 1'b0;
    if ((addr[1:0] == 2'b00) && (addr[11:10] == 2'b00))
    begin
      case (idx)
        IDX_CONTROL, IDX_SUBSEC, IDX_SECONDS, IDX_MINUTES, IDX_HOURS,
        IDX_COMPARE, IDX_INT_STAT, IDX_INT_CLR, IDX_INT_EN:
          itc_mapped = 1'b1;
        default:
          itc_mapped = 1'b0;
      endcase
    end
  endfunction

  // Presets beyond the last value run on to the 8-bit wrap
  function automatic logic [7:0] itc_step(input logic [7:0] value,
                                          input logic [7:0] last);
    if (value == last)
      itc_step = 8'h00;
    else
      itc_step = value + 8'h01;
  endfunction

  function automatic logic [7:0] itc_read(input itc_state_s s,
                                          input logic [11:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    itc_read = 8'h00;
    case (idx)
      IDX_CONTROL:  itc_read = {1'b0, s.control[6:0]};
      IDX_SUBSEC:   itc_read = s.live.subsec;
      IDX_SECONDS:  itc_read = s.live.seconds;
      IDX_MINUTES:  itc_read = s.live.minutes;
      IDX_HOURS:    itc_read = s.live.hours;
      IDX_COMPARE:  itc_read = s.compare;
      IDX_INT_STAT: itc_read = {7'h00, s.control[BIT_FLAG]};
      IDX_INT_EN:   itc_read = {7'h00, s.int_en};
      default:      itc_read = 8'h00;
    endcase
  endfunction

  // -----------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------
  always_comb
  begin
    logic       xedge;
    logic       tick;
    logic [3:0] ovf;
    logic       sel_ovf;
    logic       match;
    logic       access;
    logic       do_write;
    logic [7:0] widx;
    logic [7:0] wd;
    logic [7:0] hour_last;
    logic [7:0] nxt_count;
    xedge     = 1'b0;
    tick      = 1'b0;
    ovf       = 4'h0;
    sel_ovf   = 1'b0;
    match     = 1'b0;
    access    = 1'b0;
    do_write  = 1'b0;
    widx      = 8'h00;
    wd        = 8'h00;
    hour_last = HOUR_LAST;
    nxt_count = 8'h00;
    nxt_state = state_ff;

    // ---------------------------------------------------------------------
    // Synchronisers
    // ---------------------------------------------------------------------
    // Crystal sampled through two flops; edge taken after the second
    nxt_state.xtal_s1 = i_xtal;
    nxt_state.xtal_s2 = state_ff.xtal_s1;
    nxt_state.xtal_s3 = state_ff.xtal_s2;
    nxt_state.pd_s1   = i_power_down;
    nxt_state.pd_s2   = state_ff.pd_s1;
    xedge = state_ff.xtal_s2 & ~state_ff.xtal_s3;

    // ---------------------------------------------------------------------
    // Time keeping
    // ---------------------------------------------------------------------
    // Power-down does not gate the crystal path
    hour_last = state_ff.control[BIT_H24] ? HOUR_LAST_24 : HOUR_LAST;
    if (state_ff.control[BIT_TIME_CLOCK_ENABLE])
    begin
      if (xedge)
      begin
        nxt_state.pre = state_ff.pre + 8'h01;
        tick = (state_ff.pre == PRE_LAST);
      end
      if (tick)
      begin
        ovf[0] = (state_ff.live.subsec == SUBSEC_LAST);
        ovf[1] = ovf[0] && (state_ff.live.seconds == SEC_LAST);
        ovf[2] = ovf[1] && (state_ff.live.minutes == MIN_LAST);
        ovf[3] = ovf[2] && (state_ff.live.hours == hour_last);
        nxt_state.live.subsec = itc_step(state_ff.live.subsec, SUBSEC_LAST);
        if (ovf[0])
          nxt_state.live.seconds = itc_step(state_ff.live.seconds, SEC_LAST);
        if (ovf[1])
          nxt_state.live.minutes = itc_step(state_ff.live.minutes, MIN_LAST);
        if (ovf[2])
          nxt_state.live.hours = itc_step(state_ff.live.hours, hour_last);
      end
    end
    else
    begin
      // Stopped clock reverts to the last preset time
      nxt_state.pre  = 8'h00;
      nxt_state.live = state_ff.shadow;
    end

    // ---------------------------------------------------------------------
    // Interval counter
    // ---------------------------------------------------------------------
    // Clocked by the chosen overflow; a compare of zero means 256 units
    unique case (itc_timebase_e'(state_ff.control[BIT_TB_HI:BIT_TB_LO]))
      ITC_TB_SUBSEC:  sel_ovf = tick;
      ITC_TB_SECONDS: sel_ovf = tick & ovf[0];
      ITC_TB_MINUTES: sel_ovf = tick & ovf[1];
      ITC_TB_HOURS:   sel_ovf = tick & ovf[2];
    endcase
    if (!state_ff.control[BIT_INTERVAL_COUNT_ENABLE])
      nxt_state.interval = 8'h00;
    else if (sel_ovf)
    begin
      nxt_count = state_ff.interval + 8'h01;
      match = (nxt_count == state_ff.compare);
      nxt_state.interval = match ? 8'h00 : nxt_count;
      if (match && state_ff.control[BIT_SINGLE])
        nxt_state.control[BIT_INTERVAL_COUNT_ENABLE] = 1'b0;
    end

    // ---------------------------------------------------------------------
    // Bus answer
    // ---------------------------------------------------------------------
    // Answer only on a crystal edge, write lands at completion
    // Software must allow up to one crystal period of wait per access
    nxt_state.pready  = 1'b0;
    nxt_state.pslverr = 1'b0;
    access = i_apb.psel & i_apb.penable;
    if (access && !state_ff.pready && xedge)
    begin
      nxt_state.pready  = 1'b1;
      nxt_state.pslverr = ~itc_mapped(i_apb.paddr);
      nxt_state.prdata  = {24'h000000, itc_read(state_ff, i_apb.paddr)};
    end

    // ---------------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------------
    do_write = access & state_ff.pready & i_apb.pwrite &
               itc_mapped(i_apb.paddr);
    widx = i_apb.paddr[9:2];
    wd   = i_apb.pwdata[7:0];
    if (do_write)
    begin
      case (widx)
        IDX_CONTROL:
        begin
          nxt_state.control[6:3] = wd[6:3];
          nxt_state.control[1:0] = wd[1:0];
          if (!wd[BIT_FLAG])
            nxt_state.control[BIT_FLAG] = 1'b0;
        end
        IDX_SUBSEC:
        begin
          nxt_state.live.subsec   = wd;
          nxt_state.shadow.subsec = wd;
        end
        IDX_SECONDS:
        begin
          nxt_state.live.seconds   = wd;
          nxt_state.shadow.seconds = wd;
        end
        IDX_MINUTES:
        begin
          nxt_state.live.minutes   = wd;
          nxt_state.shadow.minutes = wd;
        end
        IDX_HOURS:
        begin
          nxt_state.live.hours   = wd;
          nxt_state.shadow.hours = wd;
        end
        IDX_COMPARE: nxt_state.compare = wd;
        IDX_INT_CLR:
        begin
          if (wd[0])
            nxt_state.control[BIT_FLAG] = 1'b0;
        end
        IDX_INT_EN:  nxt_state.int_en = wd[0];
        default:     nxt_state.int_en = state_ff.int_en;
      endcase
    end

    // ---------------------------------------------------------------------
    // Match flag and interrupt
    // ---------------------------------------------------------------------
    // A match in the clearing cycle still sets the flag
    if (match)
      nxt_state.control[BIT_FLAG] = 1'b1;

    nxt_state.irq = nxt_state.control[BIT_FLAG] & nxt_state.int_en;
    nxt_state.wake = nxt_state.irq & state_ff.pd_s2;
    nxt_state.vector = WAKE_VECTOR;
  end

  // -----------------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_ff         <= '0;
      state_ff.control <= RST_CONTROL;
      state_ff.compare <= RST_COMPARE;
      state_ff.live    <= {4{RST_TIME}};
      state_ff.shadow  <= {4{RST_TIME}};
      state_ff.vector  <= WAKE_VECTOR;
    end
    else
      state_ff <= nxt_state;
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  assign o_pready     = state_ff.pready;
  assign o_pslverr    = state_ff.pslverr;
  assign o_prdata     = state_ff.prdata;
  assign o_irq        = state_ff.irq;
  assign o_wake       = state_ff.wake;
  assign o_irq_vector = state_ff.vector;

endmodule

// [itc_pkg.sv]
// Constants, register map and carrier types of the interval timer counter
package itc_pkg;

  // ---------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------
  localparam logic [7:0] IDX_CONTROL  = 8'ha1;
  localparam logic [7:0] IDX_SUBSEC   = 8'ha2;
  localparam logic [7:0] IDX_SECONDS  = 8'ha3;
  localparam logic [7:0] IDX_MINUTES  = 8'ha4;
  localparam logic [7:0] IDX_HOURS    = 8'ha5;
  localparam logic [7:0] IDX_COMPARE  = 8'ha6;
  localparam logic [7:0] IDX_INT_STAT = 8'ha8;
  localparam logic [7:0] IDX_INT_CLR  = 8'ha9;
  localparam logic [7:0] IDX_INT_EN   = 8'haa;

  // ---------------------------------------------------------------------
  // Control register fields and reset values
  // ---------------------------------------------------------------------
  localparam int BIT_TIME_CLOCK_ENABLE   = 0;
  localparam int BIT_INTERVAL_COUNT_ENABLE   = 1;
  localparam int BIT_FLAG   = 2;
  localparam int BIT_SINGLE = 3;
  localparam int BIT_TB_LO  = 4;
  localparam int BIT_TB_HI  = 5;
  localparam int BIT_H24    = 6;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_TIME    = 8'h00;
  localparam logic [7:0] RST_COMPARE = 8'h00;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int XTAL_HZ      = 32768;
  localparam int TICKS_PER_S  = 128;
  localparam int XTAL_PER_TICK = XTAL_HZ / TICKS_PER_S;
  localparam logic [7:0] PRE_LAST = 8'(XTAL_PER_TICK - 1);
  localparam logic [7:0] SUBSEC_LAST  = 8'd127;
  localparam logic [7:0] SEC_LAST     = 8'd59;
  localparam logic [7:0] MIN_LAST     = 8'd59;
  localparam logic [7:0] HOUR_LAST_24 = 8'd23;
  localparam logic [7:0] HOUR_LAST    = 8'hff;
  localparam logic [15:0] WAKE_VECTOR = 16'h0053;

  typedef enum logic [1:0] {
    ITC_TB_SUBSEC  = 2'b00,
    ITC_TB_SECONDS = 2'b01,
    ITC_TB_MINUTES = 2'b10,
    ITC_TB_HOURS   = 2'b11
  } itc_timebase_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } itc_apb_req_s;

  typedef struct packed {
    logic [7:0] subsec;
    logic [7:0] seconds;
    logic [7:0] minutes;
    logic [7:0] hours;
  } itc_time_s;

endpackage

// [itc_interval_timer_sva.sv]
// Port-level assertions for the interval timer counter
`timescale 1ns/100ps
module itc_interval_timer_sva
  import itc_pkg::*;
(
  // Watched ports
  input wire logic         i_clk,
  input wire logic         i_sys_rst,
  input wire logic         i_xtal,
  input wire logic         i_power_down,
  input wire itc_apb_req_s i_apb,
  input wire logic         o_pready,
  input wire logic         o_pslverr,
  input wire logic [31:0]  o_prdata,
  input wire logic         o_irq,
  input wire logic         o_wake,
  input wire logic [15:0]  o_irq_vector
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_vector_fixed: assert property (o_irq_vector == WAKE_VECTOR)
    else $error("wake vector wrong");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  a_ready_cause: assert property (o_pready |->
    $past(i_apb.psel && i_apb.penable))
    else $error("ready without access phase");
  a_ready_xedge: assert property (o_pready |->
    $past(i_xtal, 3) && !$past(i_xtal, 4))
    else $error("ready not on a crystal rising edge");
  a_err_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("error outside answer");
  a_hole_refused: assert property (o_pready &&
    i_apb.paddr[11:2] == 10'h0a7 |-> o_pslverr)
    else $error("unmapped address accepted");
  a_upper_zero: assert property (o_pready |->
    o_prdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_wake_irq: assert property (o_wake |->
    o_irq && $past(i_power_down, 3))
    else $error("wake without interrupt in power-down");
  a_irq_held: assert property ($fell(o_irq) |->
    $past(i_apb.psel && i_apb.penable && i_apb.pwrite))
    else $error("interrupt dropped without a write");
endmodule
bind itc_interval_timer itc_interval_timer_sva itc_interval_timer_sva_i (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_xtal(i_xtal),
  .i_power_down(i_power_down), .i_apb(i_apb), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_prdata(o_prdata), .o_irq(o_irq),
  .o_wake(o_wake), .o_irq_vector(o_irq_vector));

// [test_itc_interval_timer.sv]
// Self-checking bench for the interval timer counter
`timescale 1ns/100ps
module test_itc_interval_timer;
  import itc_pkg::*;
  `define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("CHECK FAILED at %0t: %h vs %h", $time, a, e); end end
  logic         i_clk = 1'b0;
  logic         i_sys_rst = 1'b1;
  logic         i_xtal = 1'b0;
  logic         i_power_down = 1'b0;
  itc_apb_req_s apb = '0;
  logic         pready, pslverr, irq, wake, er;
  logic [31:0]  prdata, rd;
  logic [15:0]  vec;
  logic [7:0]   mdl [logic [7:0]];
  int           num_errors = 0, num_checks = 0, xc = 0, seed = 32'h7c06;
  int           wt;

  initial forever #5 i_clk = ~i_clk;
  // Crystal sped up to ten core cycles so whole intervals fit the run
  always @(posedge i_clk)
  begin
    xc <= (xc == 4) ? 0 : xc + 1;
    if (xc == 4) i_xtal <= ~i_xtal;
  end

  itc_interval_timer itc_interval_timer_i (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_xtal(i_xtal), .i_power_down(i_power_down),
    .i_apb(apb), .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata),
    .o_irq(irq), .o_wake(wake), .o_irq_vector(vec));

  task automatic end_sim();
    if (num_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One APB transfer; upper write bits are random since they are ignored
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
    int n;
    @(posedge i_clk);
    apb <= '{1'b1, 1'b0, w, {2'b00, idx, 2'b00}, {24'($random(seed)), d}};
    @(posedge i_clk);
    apb.penable <= 1'b1;
    for (n = 0; pready !== 1'b1 && n < 4000; n++) @(posedge i_clk);
    if (n >= 4000) begin num_errors++; end_sim(); end
    rd = prdata;
    er = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
    if (w && !er) mdl[idx] = d;
    @(negedge i_clk);
  endtask

  initial
  begin
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    `CHK(vec, WAKE_VECTOR)
    bus(0, IDX_CONTROL, 0);
    `CHK(rd, 32'(RST_CONTROL))
    bus(0, 8'ha7, 0);
    `CHK(er, 1'b1)
    bus(1, IDX_COMPARE, 8'($random(seed)));
    bus(0, IDX_COMPARE, 0);
    `CHK(rd, 32'(mdl[IDX_COMPARE]))
    // Presets make the units below the selected one roll over on the first tick
    for (int tb = 0; tb < 4; tb++)
    begin
      bus(1, IDX_SUBSEC, (tb == 0) ? 8'd5 : SUBSEC_LAST);
      bus(1, IDX_SECONDS, (tb > 1) ? SEC_LAST : 8'h00);
      bus(1, IDX_MINUTES, (tb > 2) ? MIN_LAST : 8'h00);
      bus(1, IDX_HOURS, HOUR_LAST_24);
      bus(1, IDX_COMPARE, (tb == 0) ? 8'd2 : 8'd1);
      bus(1, IDX_INT_EN, 8'h01);
      @(posedge i_clk);
      i_power_down <= (tb == 3);
      bus(1, IDX_CONTROL, 8'h4b | 8'(tb << 4));
      for (wt = 0; irq !== 1'b1; wt++)
      begin
        if (wt > 12000) begin num_errors++; end_sim(); end
        @(posedge i_clk);
      end
      // One tick is 256 crystal periods of ten core cycles each
      `CHK((wt + 40) / (XTAL_PER_TICK * 10), (tb == 0) ? 2 : 1)
      `CHK(wake, tb == 3)
      bus(0, IDX_SUBSEC, 0);
      `CHK(rd, (tb == 0) ? 32'd7 : 32'd0)
      bus(0, IDX_HOURS, 0);
      `CHK(rd, (tb == 3) ? 32'd0 : 32'(HOUR_LAST_24))
      bus(0, IDX_CONTROL, 0);
      `CHK(rd[2:1], 2'b10)
      bus(1, IDX_INT_EN, 8'h00);
      `CHK(irq, 1'b0)
      bus(0, IDX_INT_STAT, 0);
      `CHK(rd, 32'd1)
      bus(1, IDX_INT_EN, 8'h01);
      `CHK(irq, 1'b1)
      bus(1, IDX_INT_CLR, 8'h01);
      `CHK(irq, 1'b0)
      bus(1, IDX_CONTROL, 8'h00);
      bus(0, IDX_SUBSEC, 0);
      `CHK(rd, 32'(mdl[IDX_SUBSEC]))
    end
    end_sim();
  end
endmodule
